// >>> fcv_pkg.sv
// constants and type codes for the object type converter
// assumes a single core clock; no other package is needed
`default_nettype none

package fcv_pkg;

  // ****************************************************************
  // object type codes
  // ****************************************************************
  typedef enum logic [3:0] {
    FCV_BOOL   = 4'h0,
    FCV_INT8   = 4'h1,
    FCV_INT16  = 4'h2,
    FCV_INT32  = 4'h3,
    FCV_UNS8   = 4'h4,
    FCV_UNS16  = 4'h5,
    FCV_UNS32  = 4'h6,
    FCV_FLOAT  = 4'h7,
    FCV_OCTET  = 4'h8,
    FCV_BITSTR = 4'h9
  } fcv_type_e;

  // ****************************************************************
  // widths and field positions
  // ****************************************************************
  localparam int unsigned FCV_REG_W      = 32;
  localparam int unsigned FCV_BYTE_W     = 8;
  localparam int unsigned FCV_MAX_BYTES  = 4;
  localparam int unsigned FCV_LSB_POS    = 0;
  localparam int unsigned FCV_MSB_POS    = 31;
  localparam logic [7:0]  FCV_BOOL_FALSE = 8'h00;
  localparam logic [7:0]  FCV_BOOL_TRUE  = 8'hff;

  // native float: mantissa [31:8], sign [7], excess-64 exponent [6:0]
  localparam int unsigned FCV_NAT_SIGN   = 7;
  localparam int unsigned FCV_NAT_EXP_W  = 7;
  // ieee single: sign [31], exponent [30:23], fraction [22:0]
  localparam int unsigned FCV_IEEE_FRAC_W = 23;
  localparam int unsigned FCV_IEEE_EXP_W  = 8;
  // ieee exponent equals native exponent plus this offset
  localparam logic [8:0]  FCV_EXP_OFFSET = 9'h03e;
  localparam logic [8:0]  FCV_NAT_EXP_MAX = 9'h07f;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] FCV_RST_WORD   = 32'h0000_0000;

endpackage

`default_nettype wire

// >>> fcv_float_if.sv
// carries float words between the converter core and its float unit
// assumes both ends sit in the same clock domain
`default_nettype none

interface fcv_float_if;
  logic [31:0] native_in;
  logic [31:0] ieee_in;
  logic [31:0] to_ieee;
  logic [31:0] to_native;

  modport conv (input native_in, input ieee_in,
                output to_ieee, output to_native);
  modport user (output native_in, output ieee_in,
                input to_ieee, input to_native);
endinterface

`default_nettype wire

// >>> fcv_float_conv.sv
// combinational translation between native and ieee float layouts
// assumes normalised native mantissas (top bit set) or an all-zero word
`default_nettype none

module fcv_float_conv
(
  fcv_float_if.conv fl
);

  logic [8:0] nat_exp;
  logic [8:0] ieee_exp;
  logic [8:0] back_exp;

  assign nat_exp  = {2'b00, fl.native_in[fcv_pkg::FCV_NAT_EXP_W-1:0]};
  assign ieee_exp = {1'b0, fl.ieee_in[30:23]};
  assign back_exp = ieee_exp - fcv_pkg::FCV_EXP_OFFSET;

  // ****************************************************************
  // native to ieee
  // ****************************************************************
  // a zero mantissa means zero whatever the exponent field holds
  always_comb
  begin
    if (fl.native_in[31] == 1'b0)
      fl.to_ieee = fcv_pkg::FCV_RST_WORD;
    else
      fl.to_ieee = {fl.native_in[fcv_pkg::FCV_NAT_SIGN],
                    8'(nat_exp + fcv_pkg::FCV_EXP_OFFSET),
                    fl.native_in[30:8]};
  end

  // ****************************************************************
  // ieee to native
  // ****************************************************************
  // narrower native range: underflow flushes to zero, overflow saturates
  always_comb
  begin
    if (ieee_exp < fcv_pkg::FCV_EXP_OFFSET)
      fl.to_native = fcv_pkg::FCV_RST_WORD;
    else if (back_exp > fcv_pkg::FCV_NAT_EXP_MAX)
      fl.to_native = {24'hff_ffff, fl.ieee_in[31], 7'h7f};
    else
      fl.to_native = {1'b1, fl.ieee_in[22:0], fl.ieee_in[31],
                      back_exp[6:0]};
  end

endmodule

`default_nettype wire

// >>> fcv_converter.sv
// fieldbus object type converter: media/register to telegram and back
// assumes requests come from logic on i_core_clk; answer one cycle later
`default_nettype none

// What this block does
// - sent boolean becomes byte 00 for false, ff for true.
// - received boolean uses only the byte's least significant bit.
// - sent 8/16-bit integers carry only the register's low bits.
// - received signed 8/16-bit values are sign extended to 32 bits.
// - received unsigned 8/16-bit values are zero extended to 32 bits.
// - unsigned 32-bit values get bit 31 forced low both ways.
// - sent float is translated from native layout to ieee single.
// - received ieee float is translated to native layout.
// - strings move whole bytes, at least one, one element per bit.
// - sent octet string: lowest element address goes to byte msb.
// - received octet string: byte msb goes to lowest element address.
// - sent bit string: lowest element address goes to byte lsb.
// - received bit string: byte msb goes to highest element address.

module fcv_converter
#(
  parameter int unsigned MAX_BYTES = fcv_pkg::FCV_MAX_BYTES,
  localparam int unsigned BITS     = MAX_BYTES * fcv_pkg::FCV_BYTE_W,
  localparam int unsigned NB_W     = $clog2(MAX_BYTES + 1)
)
(
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_req_valid,
  input  wire logic              i_dir_send,
  input  wire logic [3:0]        i_type,
  input  wire logic [NB_W-1:0]   i_nbytes,
  input  wire logic [31:0]       i_reg_val,
  input  wire logic [BITS-1:0]   i_media,
  input  wire logic [BITS-1:0]   i_tel,
  output logic                   o_valid,
  output logic                   o_err,
  output logic [BITS-1:0]        o_tel,
  output logic [31:0]            o_reg_val,
  output logic                   o_reg_we,
  output logic [BITS-1:0]        o_media,
  output logic [BITS-1:0]        o_media_we
);

  // refused at elaboration: integers and floats need four bytes
  if (MAX_BYTES < 4)
  begin : g_bad_width
    $error("MAX_BYTES must hold a 32-bit value");
  end

  fcv_float_if fl ();

  fcv_float_conv u_float
  (
    .fl (fl.conv)
  );

  assign fl.native_in = i_reg_val;
  assign fl.ieee_in   = i_tel[31:0];

  logic [BITS-1:0] next_tel;
  logic [31:0]     next_reg;
  logic            next_reg_we;
  logic [BITS-1:0] next_media;
  logic [BITS-1:0] next_media_we;
  logic            next_err;
  logic            len_bad;

  assign len_bad  = (i_nbytes == '0) || (i_nbytes > NB_W'(MAX_BYTES));

  // ****************************************************************
  // conversion
  // ****************************************************************
  always_comb
  begin
    next_tel      = '0;
    next_reg      = fcv_pkg::FCV_RST_WORD;
    next_reg_we   = 1'b0;
    next_media    = '0;
    next_media_we = '0;
    next_err      = 1'b0;
    case (i_type)
      fcv_pkg::FCV_BOOL:
      begin
        if (i_dir_send)
          next_tel[7:0] = i_media[0] ? fcv_pkg::FCV_BOOL_TRUE
                                     : fcv_pkg::FCV_BOOL_FALSE;
        else
        begin
          next_media[0]    = i_tel[fcv_pkg::FCV_LSB_POS];
          next_media_we[0] = 1'b1;
        end
      end
      fcv_pkg::FCV_INT8, fcv_pkg::FCV_UNS8:
      begin
        if (i_dir_send)
          next_tel[7:0] = i_reg_val[7:0];
        else if (i_type == 4'(fcv_pkg::FCV_INT8))
          next_reg = {{24{i_tel[7]}}, i_tel[7:0]};
        else
          next_reg = {24'h00_0000, i_tel[7:0]};
        next_reg_we = !i_dir_send;
      end
      fcv_pkg::FCV_INT16, fcv_pkg::FCV_UNS16:
      begin
        if (i_dir_send)
          next_tel[15:0] = i_reg_val[15:0];
        else if (i_type == 4'(fcv_pkg::FCV_INT16))
          next_reg = {{16{i_tel[15]}}, i_tel[15:0]};
        else
          next_reg = {16'h0000, i_tel[15:0]};
        next_reg_we = !i_dir_send;
      end
      fcv_pkg::FCV_INT32:
      begin
        if (i_dir_send)
          next_tel[31:0] = i_reg_val;
        else
          next_reg = i_tel[31:0];
        next_reg_we = !i_dir_send;
      end
      fcv_pkg::FCV_UNS32:
      begin
        if (i_dir_send)
          next_tel[31:0] = {1'b0, i_reg_val[30:0]};
        else
          next_reg = {1'b0, i_tel[30:0]};
        next_reg_we = !i_dir_send;
      end
      fcv_pkg::FCV_FLOAT:
      begin
        if (i_dir_send)
          next_tel[31:0] = fl.to_ieee;
        else
          next_reg = fl.to_native;
        next_reg_we = !i_dir_send;
      end
      fcv_pkg::FCV_OCTET, fcv_pkg::FCV_BITSTR:
      begin
        next_err = len_bad;
        // whole bytes, byte k holds elements 8k..8k+7
        for (int k = 0; k < MAX_BYTES; k++)
        begin
          if (!len_bad && (k < int'(i_nbytes)))
          begin
            for (int j = 0; j < 8; j++)
            begin
              if (i_type == 4'(fcv_pkg::FCV_OCTET))
              begin
                next_tel[8*k+7-j] = i_media[8*k+j];
                next_media[8*k+j] = i_tel[8*k+7-j];
              end
              else
              begin
                next_tel[8*k+j]   = i_media[8*k+j];
                next_media[8*k+j] = i_tel[8*k+j];
              end
              next_media_we[8*k+j] = !i_dir_send;
            end
          end
        end
        if (!i_dir_send)
          next_tel = '0;
        else
          next_media = '0;
      end
      default:
        next_err = 1'b1;
    endcase
  end

  // ****************************************************************
  // answer registers
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_valid <= 1'b0;
    else
      o_valid <= i_req_valid;
  end

  // outputs here other than the write strobes only move on a request so the last answer stays readable
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_err      <= 1'b0;
      o_tel      <= '0;
      o_reg_val  <= fcv_pkg::FCV_RST_WORD;
      o_reg_we   <= 1'b0;
      o_media    <= '0;
      o_media_we <= '0;
    end
    else if (i_req_valid)
    begin
      o_err      <= next_err;
      o_tel      <= next_err ? '0 : next_tel;
      o_reg_val  <= next_reg;
      o_reg_we   <= next_reg_we && !next_err;
      o_media    <= next_media;
      o_media_we <= next_err ? '0 : next_media_we;
    end
    else
    begin
      o_reg_we   <= 1'b0;
      o_media_we <= '0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_req(logic snd, logic [3:0] ty);
    i_req_valid && (i_dir_send == snd) && (i_type == ty);
  endsequence

  property p_bool_send;
    s_req(1'b1, 4'h0) |=> o_valid && (o_tel[7:0] == {8{$past(i_media[0])}});
  endproperty
  a_bool_send: assert property (p_bool_send)
    else $error("boolean byte wrong");

  property p_bool_recv;
    s_req(1'b0, 4'h0) |=> o_media_we[0] && (o_media[0] == $past(i_tel[0]));
  endproperty
  a_bool_recv: assert property (p_bool_recv)
    else $error("boolean element wrong");

  property p_int8_send;
    s_req(1'b1, 4'h1) |=> (o_tel[31:8] == 24'h0)
      && (o_tel[7:0] == $past(i_reg_val[7:0]));
  endproperty
  a_int8_send: assert property (p_int8_send)
    else $error("int8 truncation wrong");

  property p_int16_recv;
    s_req(1'b0, 4'h2) |=> o_reg_we
      && (o_reg_val == {{16{$past(i_tel[15])}}, $past(i_tel[15:0])});
  endproperty
  a_int16_recv: assert property (p_int16_recv)
    else $error("int16 sign extension wrong");

  property p_uns8_recv;
    s_req(1'b0, 4'h4) |=> o_reg_val == {24'h0, $past(i_tel[7:0])};
  endproperty
  a_uns8_recv: assert property (p_uns8_recv)
    else $error("uns8 zero extension wrong");

  property p_uns32;
    s_req(1'b1, 4'h6) or s_req(1'b0, 4'h6)
      |=> !o_tel[31] && !o_reg_val[31];
  endproperty
  a_uns32: assert property (p_uns32)
    else $error("uns32 top bit set");

  property p_int32_send;
    s_req(1'b1, 4'h3) |=> o_tel[31:0] == $past(i_reg_val);
  endproperty
  a_int32_send: assert property (p_int32_send)
    else $error("int32 copy wrong");

  property p_float_sign;
    s_req(1'b1, 4'h7) ##0 i_reg_val[31]
      |=> o_tel[31] == $past(i_reg_val[7]);
  endproperty
  a_float_sign: assert property (p_float_sign)
    else $error("float sign lost");

  property p_octet_send;
    s_req(1'b1, 4'h8) ##0 (i_nbytes == NB_W'(2))
      |=> (o_tel[7] == $past(i_media[0])) && (o_tel[15] == $past(i_media[8]));
  endproperty
  a_octet_send: assert property (p_octet_send)
    else $error("octet order wrong");

  property p_bitstr_recv;
    s_req(1'b0, 4'h9) ##0 (i_nbytes == NB_W'(1))
      |=> (o_media[7] == $past(i_tel[7])) && (o_media_we[7:0] == 8'hff);
  endproperty
  a_bitstr_recv: assert property (p_bitstr_recv)
    else $error("bit string order wrong");

  property p_len_err;
    s_req(1'b1, 4'h8) ##0 (i_nbytes == '0) |=> o_err && (o_tel == '0);
  endproperty
  a_len_err: assert property (p_len_err)
    else $error("empty string not refused");

endmodule

`default_nettype wire

// >>> fcv_engine_model.sv
// fieldbus engine model: supplies receive images, takes send images
// assumes the converter answers one cycle after each request
`default_nettype none

module fcv_engine_model
#(
  parameter int unsigned BITS = 32
)
(
  input  wire logic            i_core_clk,
  input  wire logic            i_load,
  input  wire logic [BITS-1:0] i_image,
  input  wire logic            i_valid,
  input  wire logic [BITS-1:0] i_tel_out,
  output logic      [BITS-1:0] o_tel_line,
  output logic      [BITS-1:0] o_taken
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [BITS-1:0] noise = '0;

  // idle line moves every cycle so a stale image is never seen
  always @(posedge i_core_clk)
    noise <= ~noise ^ {noise[BITS-2:0], 1'b1};

  assign o_tel_line = i_load ? i_image : noise;

  // image is taken in the cycle the converter strobes it out
  assign o_taken = i_valid ? i_tel_out : '0;
endmodule

`default_nettype wire

// >>> fcv_converter_tb_top.sv
// self-checking bench for the object type converter
// assumes fcv_converter, fcv_engine_model and fcv_pkg are compiled
`default_nettype none

module fcv_converter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 0, nrst = 0, req = 0, dir = 0, load = 0;
  logic [3:0]  typ = 0;
  logic [2:0]  nb = 0;
  logic [31:0] regv = 0, media = 0, img = 0;
  logic        o_valid, o_err, o_reg_we;
  logic [31:0] tel, o_reg, o_med, o_we, tel_line, taken;
  logic [31:0] e_tel, e_reg, e_med, e_we, seed = 32'd25;
  logic        e_err, e_rwe, pend = 0;
  int          failures = 0, samples_checked = 0;

  initial forever #4 clk = ~clk;

  fcv_converter fcv_converter_inst (.i_core_clk(clk), .i_nrst(nrst),
    .i_req_valid(req), .i_dir_send(dir), .i_type(typ), .i_nbytes(nb),
    .i_reg_val(regv), .i_media(media), .i_tel(tel_line),
    .o_valid(o_valid), .o_err(o_err), .o_tel(tel), .o_reg_val(o_reg),
    .o_reg_we(o_reg_we), .o_media(o_med), .o_media_we(o_we));

  fcv_engine_model fcv_engine_model_inst (.i_core_clk(clk),
    .i_load(load), .i_image(img), .i_valid(o_valid), .i_tel_out(tel),
    .o_tel_line(tel_line), .o_taken(taken));

  // ****************************************************************
  // expectation helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] rev8(logic [31:0] x);
    logic [31:0] r;
    for (int i = 0; i < 32; i++)
      r[i] = x[(i & ~7) | (7 - (i & 7))];
    return r;
  endfunction

  task automatic calc();
    logic [31:0] m;
    m = 32'((64'h1 << (8 * nb)) - 1);
    e_err = typ > 4'h9 || (typ >= 4'h8 && (nb == 3'h0 || nb > 3'h4));
    {e_tel, e_reg, e_med, e_we, e_rwe} = '0;
    if (!e_err && dir)
      case (typ)
        4'h0: e_tel = media[0] ? 32'h0000_00ff : 32'h0;
        4'h1, 4'h4: e_tel = {24'h0, regv[7:0]};
        4'h2, 4'h5: e_tel = {16'h0, regv[15:0]};
        4'h3: e_tel = regv;
        4'h6: e_tel = {1'b0, regv[30:0]};
        4'h7: e_tel = {regv[7], 8'(regv[6:0]) + 8'h3e, regv[30:8]};
        4'h8: e_tel = rev8(media) & m;
        default: e_tel = media & m;
      endcase
    else if (!e_err)
      case (typ)
        4'h0: {e_med, e_we} = {31'h0, img[0], 32'h1};
        4'h8: {e_med, e_we} = {rev8(img) & m, m};
        4'h9: {e_med, e_we} = {img & m, m};
        default:
        begin
          e_rwe = 1'b1;
          case (typ)
            4'h1: e_reg = {{24{img[7]}}, img[7:0]};
            4'h2: e_reg = {{16{img[15]}}, img[15:0]};
            4'h3: e_reg = img;
            4'h4: e_reg = {24'h0, img[7:0]};
            4'h5: e_reg = {16'h0, img[15:0]};
            4'h6: e_reg = {1'b0, img[30:0]};
            default: e_reg = {1'b1, img[22:0], img[31],
                              7'(img[30:23] - 8'h3e)};
          endcase
        end
      endcase
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic check_out();
    chk("valid", {31'h0, pend}, {31'h0, o_valid});
    chk("reg_we", {31'h0, pend & e_rwe}, {31'h0, o_reg_we});
    chk("media_we", pend ? e_we : 32'h0, o_we);
    if (pend)
    begin
      chk("err", {31'h0, e_err}, {31'h0, o_err});
      chk("tel", e_tel, taken);
      chk("media", e_med, o_med & e_we);
      if (e_rwe)
        chk("reg", e_reg, o_reg);
    end
  endtask

  task automatic step(logic v, logic d, logic [3:0] t, logic [2:0] n,
                      logic [31:0] r, logic [31:0] me, logic [31:0] im);
    @(negedge clk);
    check_out();
    {req, dir, typ, nb, regv, media, img, load} = {v, d, t, n, r, me, im, v};
    calc();
    pend = v;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    logic [31:0] r1, r2, r3;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("valid in reset", 32'h0, {31'h0, o_valid});
    nrst = 1'b1;
    // corner cases, back to back
    step(1, 1, 4'h0, 0, 0, 32'h1, 0);
    step(1, 1, 4'h0, 0, 0, 32'hfffe, 0);
    step(1, 0, 4'h0, 0, 0, 0, 32'hfe);
    step(1, 0, 4'h0, 0, 0, 0, 32'h01);
    step(1, 1, 4'h6, 0, 32'hffff_ffff, 0, 0);
    step(1, 0, 4'h6, 0, 0, 0, 32'hffff_ffff);
    step(1, 0, 4'h1, 0, 0, 0, 32'h0000_0080);
    step(1, 0, 4'h5, 0, 0, 0, 32'hffff_8001);
    step(1, 1, 4'h8, 4, 0, 32'h8000_0001, 0);
    step(1, 1, 4'h8, 2, 0, 32'h0000_0101, 0);
    step(1, 0, 4'h8, 3, 0, 0, 32'hff01_8001);
    step(1, 1, 4'h9, 1, 0, 32'hffff_ff81, 0);
    step(1, 0, 4'h9, 2, 0, 0, 32'hffff_8001);
    step(1, 0, 4'h9, 1, 0, 0, 32'hffff_ff81);
    step(1, 1, 4'h8, 0, 0, 32'hff, 0);
    step(1, 0, 4'h9, 5, 0, 0, 32'hff);
    step(1, 1, 4'hf, 1, 32'h1, 32'h1, 0);
    step(1, 1, 4'h7, 0, 32'h8000_0041, 0, 0);
    step(1, 0, 4'h7, 0, 0, 0, 32'h3f80_0000);
    step(0, 0, 4'h0, 0, 0, 0, 0);
    $display("test directed done");
    for (int i = 0; i < 400; i++)
    begin
      r1 = xs();
      r2 = xs();
      r3 = xs();
      // floats kept in the range both layouts can hold
      if (r1[7:4] == 4'h7)
      begin
        r2[31] = 1'b1;
        r3[30:23] = 8'h3e + {1'b0, r3[6:0]};
      end
      step(r1[0] | r1[1], r1[2], r1[7:4], r1[10:8], r2, r2, r3);
    end
    step(0, 0, 4'h0, 0, 0, 0, 0);
    step(0, 0, 4'h0, 0, 0, 0, 0);
    $display("test random done");
    stop_test();
  end

  initial
  begin
    #20us;
    failures++;
    $display("ERROR watchdog expected end seen hang");
    stop_test();
  end
endmodule

`default_nettype wire
